//--- event_status_defines.vh
// Constants for the instrument event-status block
`ifndef EVENT_STATUS_DEFINES_VH
`define EVENT_STATUS_DEFINES_VH
// Register select codes for the query/command port
`define SEL_STATUS_BYTE      3'h0
`define SEL_SERVICE_MASK     3'h1
`define SEL_STANDARD_STATUS  3'h2
`define SEL_STANDARD_MASK    3'h3
`define SEL_MEASURE_STATUS   3'h4
`define SEL_MEASURE_MASK     3'h5
`define SEL_MONITOR_STATUS   3'h6
`define SEL_MONITOR_MASK     3'h7
// Standard event status bit positions
`define STD_OPC_BIT   0
`define STD_RQC_BIT   1
`define STD_QYE_BIT   2
`define STD_DDE_BIT   3
`define STD_EXE_BIT   4
`define STD_CME_BIT   5
`define STD_URQ_BIT   6
`define STD_PON_BIT   7
// Status byte bit positions
`define STB_MEAS_BIT  0
`define STB_MON_BIT   1
`define STB_MAV_BIT   4
`define STB_ESB_BIT   5
`define STB_MSS_BIT   6
// Usable bits of the device-specific event registers
`define MEASURE_USED  8'h7F
`define MONITOR_USED  8'h0F
`define MASK_RESET    8'h00
`endif

//--- instrument_event_status.v
// Event-status and interface-message logic of the remote-control port
//
// Summary of operation
// - Status byte bit 5 is masked standard OR
// - Standard register clears on clear, query, power-up
// - Power-on flag bit 7 set at power-up
// - Device-dependent error bit 3 never used
// - Command error sets bit 5, discards message
// - Execution error sets bit 4
// - Query error sets bit 2, clears output queue
// - Operation complete sets bit 0 when idle
// - Standard mask bits gate the summary
// - Status byte bit 0 is masked measurement OR
// - Status byte bit 1 is masked monitor OR
// - Device registers clear on clear, query, power-up
// - Measurement register bit meanings, bit 7 unused
// - Monitor register bit meanings, bits 7-4 unused
// - Event registers read-only, masks read-write
// - Go-to-local leaves remote state
// - Local lockout disables all panel keys
// - Device clear empties input and output
// - Group trigger runs exactly one sampling
// - Rising enabled status bit sets summary, request only while remote enable is high
// - Status bit 4 follows output queue not empty
`timescale 1ns/1ps
`include "event_status_defines.vh"

module instrument_event_status (
   input  wire       clock,
   input  wire       resetn,
   // Register access from the command parser
   input  wire [2:0] regSelect,
   input  wire       regWrite,
   input  wire       regRead,
   input  wire [7:0] regWriteData,
   output reg  [7:0] regReadData,
   output reg        regReadValid,
   input  wire       clearStatusCmd,
   // Event sources
   input  wire       commandError,
   input  wire       executionError,
   input  wire       queueEmptyRead,
   input  wire       queueOverflow,
   input  wire       queueDataLost,
   input  wire       newCommandWhilePending,
   input  wire       opcCommand,
   input  wire       priorMessagesBusy,
   input  wire [7:0] measureEvents,
   input  wire [7:0] monitorEvents,
   input  wire       outputQueueNotEmpty,
   // Interface messages
   input  wire       remoteEnable,
   input  wire       goToLocalMsg,
   input  wire       localLockoutMsg,
   input  wire       deviceClearMsg,
   input  wire       selectedClearMsg,
   input  wire       groupTriggerMsg,
   input  wire       serialPoll,
   // Effects and status
   output reg        discardToTerminator,
   output reg        clearOutputQueue,
   output reg        clearInputBuffer,
   output reg        triggerSample,
   output reg        remoteState,
   output reg        keysLocked,
   output reg        serviceRequest,
   output reg  [7:0] statusByte
);

   //----------------------------------------------------------------
   // State
   //----------------------------------------------------------------
   reg [7:0] standardStatus_reg;
   reg [7:0] standardMask_reg;
   reg [7:0] measureStatus_reg;
   reg [7:0] measureMask_reg;
   reg [7:0] monitorStatus_reg;
   reg [7:0] monitorMask_reg;
   reg [7:0] serviceMask_reg;
   reg       opcPending_reg;
   reg       powerOn_reg;
   reg [7:0] stbRaw_reg;
   reg       masterSummary_reg;

   // Masked OR of a register against its enable
   function anyMasked;
      input [7:0] value;
      input [7:0] mask;
      begin
         anyMasked = |(value & mask);
      end
   endfunction

   wire readStd  = regRead && (regSelect == `SEL_STANDARD_STATUS);
   wire readMeas = regRead && (regSelect == `SEL_MEASURE_STATUS);
   wire readMon  = regRead && (regSelect == `SEL_MONITOR_STATUS);
   wire queryErr = queueEmptyRead | queueOverflow | queueDataLost | newCommandWhilePending;
   wire devClear = deviceClearMsg | selectedClearMsg;

   // Unused positions are masked before they can latch
   wire [7:0] measSet = measureEvents & `MEASURE_USED;
   wire [7:0] monSet  = monitorEvents & `MONITOR_USED;

   //----------------------------------------------------------------
   // Remote enable line synchroniser
   //----------------------------------------------------------------
   // The enable level comes straight off the bus cable, so it passes
   // three flops and a new level is taken only when the last two agree.
   // This costs four clocks of latency, far below any message spacing.
   reg [2:0] renSync_reg;
   reg       renLevel_reg;
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         renSync_reg  <= 3'h0;
         renLevel_reg <= 1'b0;
      end else begin
         renSync_reg <= {renSync_reg[1:0], remoteEnable};
         if (renSync_reg[1] == renSync_reg[2]) begin
            renLevel_reg <= renSync_reg[2];
         end
      end
   end

   //----------------------------------------------------------------
   // Standard event bits set this cycle
   //----------------------------------------------------------------
   reg [7:0] stdSet;
   always @* begin
      stdSet = 8'h00;
      stdSet[`STD_PON_BIT] = powerOn_reg;
      stdSet[`STD_CME_BIT] = commandError;
      stdSet[`STD_EXE_BIT] = executionError;
      stdSet[`STD_QYE_BIT] = queryErr;
      stdSet[`STD_OPC_BIT] = opcPending_reg & ~priorMessagesBusy;
      // Bits 6, 3 and 1 are never set
   end

   //----------------------------------------------------------------
   // Power-on flag and operation-complete tracking
   //----------------------------------------------------------------
   // The flag is high for the first clock after reset only, so the
   // power-on bit lands exactly once per power cycle
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         powerOn_reg    <= 1'b1;
         opcPending_reg <= 1'b0;
      end else begin
         powerOn_reg <= 1'b0;
         // Completion waits until earlier messages drain
         if (opcCommand) begin
            opcPending_reg <= 1'b1;
         end else if (!priorMessagesBusy) begin
            opcPending_reg <= 1'b0;
         end
      end
   end

   //----------------------------------------------------------------
   // Standard event register: set beats clear so no event is lost
   //----------------------------------------------------------------
   // A query returns the old value and reloads with this cycle's events
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         standardStatus_reg <= 8'h00;
      end else if (clearStatusCmd || readStd) begin
         standardStatus_reg <= stdSet;
      end else begin
         standardStatus_reg <= standardStatus_reg | stdSet;
      end
   end

   //----------------------------------------------------------------
   // Measurement event register
   //----------------------------------------------------------------
   // Bits latch until a query or clear status, even if the source drops
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         measureStatus_reg <= 8'h00;
      end else if (clearStatusCmd || readMeas) begin
         measureStatus_reg <= measSet;
      end else begin
         measureStatus_reg <= measureStatus_reg | measSet;
      end
   end

   //----------------------------------------------------------------
   // Monitor event register
   //----------------------------------------------------------------
   // Same latching as the measurement register; upper nibble stays zero
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         monitorStatus_reg <= 8'h00;
      end else if (clearStatusCmd || readMon) begin
         monitorStatus_reg <= monSet;
      end else begin
         monitorStatus_reg <= monitorStatus_reg | monSet;
      end
   end

   //----------------------------------------------------------------
   // Mask registers, written only by their own commands
   //----------------------------------------------------------------
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         serviceMask_reg  <= `MASK_RESET;
         standardMask_reg <= `MASK_RESET;
         measureMask_reg  <= `MASK_RESET;
         monitorMask_reg  <= `MASK_RESET;
      end else if (regWrite) begin
         case (regSelect)
            `SEL_SERVICE_MASK:  serviceMask_reg  <= regWriteData;
            `SEL_STANDARD_MASK: standardMask_reg <= regWriteData;
            `SEL_MEASURE_MASK:  measureMask_reg  <= regWriteData;
            `SEL_MONITOR_MASK:  monitorMask_reg  <= regWriteData;
            default: ;  // Status registers ignore writes
         endcase
      end
   end

   //----------------------------------------------------------------
   // Status byte: summaries registered, MSS latched on rising edge
   //----------------------------------------------------------------
   reg [7:0] stbNext;
   always @* begin
      stbNext = 8'h00;
      stbNext[`STB_MEAS_BIT] = anyMasked(measureStatus_reg, measureMask_reg);
      stbNext[`STB_MON_BIT]  = anyMasked(monitorStatus_reg, monitorMask_reg);
      stbNext[`STB_MAV_BIT]  = outputQueueNotEmpty;
      stbNext[`STB_ESB_BIT]  = anyMasked(standardStatus_reg, standardMask_reg);
   end

   // Only a 0-to-1 change of an enabled bit raises a request
   wire [7:0] stbRise = stbNext & ~stbRaw_reg & serviceMask_reg;

   // A fresh rise wins over a clear status in the same cycle
   wire       mssNext = (|stbRise) | (masterSummary_reg & ~clearStatusCmd);

   // Registered summaries; bit 6 carries the latched master summary
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         stbRaw_reg        <= 8'h00;
         masterSummary_reg <= 1'b0;
         statusByte        <= 8'h00;
      end else begin
         stbRaw_reg        <= stbNext;
         masterSummary_reg <= mssNext;
         statusByte        <= {stbNext[7], mssNext, stbNext[5:0]};
      end
   end

   // The request line clears on a poll, while the master summary
   // stays until clear status; no request goes out while remote enable is low
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         serviceRequest <= 1'b0;
      end else if (|stbRise) begin
         serviceRequest <= renLevel_reg;
      end else if (serialPoll || clearStatusCmd) begin
         serviceRequest <= 1'b0;
      end
   end

   //----------------------------------------------------------------
   // Read port: one-cycle answer
   //----------------------------------------------------------------
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         regReadData  <= 8'h00;
         regReadValid <= 1'b0;
      end else begin
         regReadValid <= regRead;
         if (regRead) begin
            case (regSelect)
               `SEL_STATUS_BYTE:     regReadData <= statusByte;
               `SEL_SERVICE_MASK:    regReadData <= serviceMask_reg;
               `SEL_STANDARD_STATUS: regReadData <= standardStatus_reg;
               `SEL_STANDARD_MASK:   regReadData <= standardMask_reg;
               `SEL_MEASURE_STATUS:  regReadData <= measureStatus_reg;
               `SEL_MEASURE_MASK:    regReadData <= measureMask_reg;
               `SEL_MONITOR_STATUS:  regReadData <= monitorStatus_reg;
               `SEL_MONITOR_MASK:    regReadData <= monitorMask_reg;
               default:              regReadData <= 8'h00;
            endcase
         end
      end
   end

   //----------------------------------------------------------------
   // Interface messages and error effects (one-cycle pulses)
   //----------------------------------------------------------------
   // Each effect is a single-cycle pulse one clock after its cause,
   // so one trigger message can never start two samplings
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         discardToTerminator <= 1'b0;
         clearOutputQueue    <= 1'b0;
         clearInputBuffer    <= 1'b0;
         triggerSample       <= 1'b0;
      end else begin
         discardToTerminator <= commandError;
         clearOutputQueue    <= queryErr | devClear;
         clearInputBuffer    <= devClear;
         triggerSample       <= groupTriggerMsg;
      end
   end

   //----------------------------------------------------------------
   // Remote and lockout state
   //----------------------------------------------------------------
   // Lockout holds while remote enable stays asserted; dropping the
   // enable line frees the keys and forces local operation
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         keysLocked <= 1'b0;
      end else if (!renLevel_reg) begin
         keysLocked <= 1'b0;
      end else if (localLockoutMsg) begin
         keysLocked <= 1'b1;
      end
   end

   // Lockout sets remote; go-to-local leaves the keys locked
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         remoteState <= 1'b0;
      end else if (goToLocalMsg || !renLevel_reg) begin
         remoteState <= 1'b0;
      end else if (localLockoutMsg) begin
         remoteState <= 1'b1;
      end
   end

endmodule // instrument_event_status

//--- instrument_event_status_assertions.sv
// Port-level assertions for the event-status block
`timescale 1ns/1ps
module instrument_event_status_assertions (
   input wire       clock, resetn, regRead, regWrite, regReadValid, commandError,
   input wire       queueEmptyRead, queueOverflow, queueDataLost, newCommandWhilePending,
   input wire       clearStatusCmd, goToLocalMsg, localLockoutMsg, remoteEnable, deviceClearMsg,
   input wire       selectedClearMsg, groupTriggerMsg, discardToTerminator, clearOutputQueue,
   input wire       clearInputBuffer, triggerSample, remoteState, keysLocked, outputQueueNotEmpty,
   input wire [2:0] regSelect,
   input wire [7:0] regWriteData, regReadData, statusByte, measureEvents
);
   // --------
   // Mask mirrors
   // --------
   reg  [7:0] stdMask_reg, measMask_reg;
   wire       quiet = !(clearStatusCmd | regRead | regWrite);
   wire       qErr  = queueEmptyRead | queueOverflow | queueDataLost | newCommandWhilePending;
   // Summary checks only hold while a clear or mask change cannot interfere
   always @(posedge clock or negedge resetn)
      if (!resetn) begin
         stdMask_reg  <= 8'h00;
         measMask_reg <= 8'h00;
      end else if (regWrite) begin
         if (regSelect == 3'h3) stdMask_reg <= regWriteData;
         if (regSelect == 3'h5) measMask_reg <= regWriteData;
      end
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   // --------
   // Checks
   // --------
   a_std_summary: assert property (commandError && stdMask_reg[5] && quiet ##1 quiet
      |=> statusByte[5]) else $error("std summary low");
   a_meas_summary: assert property (|(measureEvents & measMask_reg & 8'h7F) && quiet
      ##1 quiet |=> statusByte[0]) else $error("meas summary low");
   a_unused_std_bits: assert property (regReadValid && $past(regSelect) == 3'h2
      |-> (regReadData & 8'h4A) == 8'h00) else $error("unused std bit set");
   a_cmd_discard: assert property (commandError |=> discardToTerminator)
      else $error("no discard");
   a_query_flush: assert property (qErr |=> clearOutputQueue)
      else $error("no flush");
   a_clear_both: assert property (deviceClearMsg || selectedClearMsg
      |=> clearInputBuffer && clearOutputQueue) else $error("clear incomplete");
   a_one_trigger: assert property ($past(resetn)
      |-> triggerSample == $past(groupTriggerMsg)) else $error("trigger wrong");
   a_go_local: assert property (goToLocalMsg && !localLockoutMsg |=> !remoteState)
      else $error("still remote");
   a_lock_keys: assert property (localLockoutMsg && remoteEnable && !goToLocalMsg
      |=> keysLocked) else $error("keys free");
   a_queue_flag: assert property ($past(resetn)
      |-> statusByte[4] == $past(outputQueueNotEmpty)) else $error("queue flag wrong");
   c_read: cover property (regReadValid);
   c_trigger: cover property (triggerSample);
   c_request: cover property (statusByte[6]);
endmodule // instrument_event_status_assertions

//--- remote_controller_model.sv
// Remote controller model that sends register commands and queries
`timescale 1ns/1ps
module remote_controller_model (
   input  wire       clock,
   input  wire       cWr,
   input  wire       cRd,
   input  wire [2:0] cSel,
   input  wire [7:0] cDat,
   output reg  [2:0] regSelect    = 3'h0,
   output reg        regWrite     = 1'b0,
   output reg        regRead      = 1'b0,
   output reg  [7:0] regWriteData = 8'h00
);
   // One request a cycle; idle data toggles so a stale byte never looks fresh
   always @(posedge clock) begin
      regSelect    <= cSel;
      regWrite     <= cWr;
      regRead      <= cRd;
      regWriteData <= cWr ? cDat : ~regWriteData;
   end
endmodule // remote_controller_model

//--- instrument_event_status_bench.sv
// Self-checking bench for the instrument event-status block
`timescale 1ns/1ps
module instrument_event_status_bench;
   logic        clock = 0, resetn = 0, busy = 0, remEn = 1, outQ = 0, cWr = 0, cRd = 0;
   logic [13:0] pul = 0;
   logic [7:0]  meas = 0, mon = 0, cDat = 0, d, m, e;
   logic [2:0]  cSel = 0;
   wire  [2:0]  sel;
   wire  [7:0]  wData, rData, stb;
   wire         wEn, rEn, rValid, discard, clrOut, clrIn, trig, remote, locked, srq;
   int          bad_count = 0, cmp_count = 0, i;
   // --------
   // Clock, controller and device
   // --------
   initial forever #2.5 clock = ~clock;
   remote_controller_model remote_controller_model_inst (.clock(clock), .cWr(cWr), .cRd(cRd),
      .cSel(cSel), .cDat(cDat), .regSelect(sel), .regWrite(wEn), .regRead(rEn),
      .regWriteData(wData));
   instrument_event_status instrument_event_status_inst (.clock(clock), .resetn(resetn),
      .regSelect(sel), .regWrite(wEn), .regRead(rEn), .regWriteData(wData), .regReadData(rData),
      .regReadValid(rValid), .clearStatusCmd(pul[13]), .commandError(pul[0]),
      .executionError(pul[1]), .queueEmptyRead(pul[2]), .queueOverflow(pul[3]),
      .queueDataLost(pul[4]), .newCommandWhilePending(pul[5]), .opcCommand(pul[6]),
      .priorMessagesBusy(busy), .measureEvents(meas), .monitorEvents(mon),
      .outputQueueNotEmpty(outQ), .remoteEnable(remEn), .goToLocalMsg(pul[7]),
      .localLockoutMsg(pul[8]), .deviceClearMsg(pul[9]), .selectedClearMsg(pul[10]),
      .groupTriggerMsg(pul[11]), .serialPoll(pul[12]), .discardToTerminator(discard),
      .clearOutputQueue(clrOut), .clearInputBuffer(clrIn), .triggerSample(trig),
      .remoteState(remote), .keysLocked(locked), .serviceRequest(srq), .statusByte(stb));
   // --------
   // Tasks
   // --------
   task chk(input logic [7:0] x, input logic [7:0] y);
      cmp_count++;
      if (y !== x) begin
         bad_count++;
         $display("wrong value at %0t: want %h got %h", $time, x, y);
      end
   endtask
   task test_done;
      $display("compares %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task pulse(input int k);
      @(posedge clock) pul[k] <= 1'b1;
      @(posedge clock) pul[k] <= 1'b0;
   endtask
   task wrReg(input logic [2:0] s, input logic [7:0] v);
      @(posedge clock) {cSel, cDat, cWr} <= {s, v, 1'b1};
      @(posedge clock) cWr <= 1'b0;
      @(posedge clock);
   endtask
   // Query waits a bounded number of cycles for the answer pulse
   task rdReg(input logic [2:0] s);
      int n;
      @(posedge clock) {cSel, cRd} <= {s, 1'b1};
      @(posedge clock) cRd <= 1'b0;
      n = 0;
      do begin
         @(posedge clock);
         #1 n++;
      end while (rValid !== 1'b1 && n < 4);
      d = rData;
      chk(8'h01, {7'h0, rValid});
   endtask
   // Watchdog sized well above the whole sequence
   initial begin
      repeat (20000) @(posedge clock);
      bad_count++;
      test_done;
   end
   initial begin
      i = $urandom(84);
      repeat (20) @(posedge clock);
      resetn <= 1'b1;
      rdReg(3'h2); chk(8'h80, d);
      rdReg(3'h2); chk(8'h00, d);
      for (i = 0; i < 6; i++) begin
         pulse(i);
         #1 chk({6'h0, i > 1, i == 0}, {6'h0, clrOut, discard});
         rdReg(3'h2); chk(8'h01 << (i == 0 ? 5 : i == 1 ? 4 : 2), d);
      end
      @(posedge clock) busy <= 1'b1;
      pulse(6);
      repeat (3) @(posedge clock);
      rdReg(3'h2); chk(8'h00, d);
      @(posedge clock) busy <= 1'b0;
      repeat (2) @(posedge clock);
      rdReg(3'h2); chk(8'h01, d);
      $display("test standard events done");
      // Random masks and events; odd passes clear by command instead of query
      for (i = 0; i < 12; i++) begin
         m = $urandom;
         e = $urandom;
         wrReg(3'h3, m); rdReg(3'h3); chk(m, d);
         wrReg(3'h5, m); wrReg(3'h7, ~m); wrReg(3'h4, 8'hFF);
         @(posedge clock) {meas, mon, pul[0]} <= {e, ~e, 1'b1};
         @(posedge clock) {meas, mon, pul[0]} <= 17'h0;
         repeat (2) @(posedge clock);
         rdReg(3'h0);
         chk({2'h0, m[5], 3'h0, |(~e & ~m & 8'h0F), |(e & m & 8'h7F)}, d);
         rdReg(3'h4); chk(e & 8'h7F, d);
         if (i[0]) pulse(13);
         rdReg(3'h6); chk(i[0] ? 8'h00 : ~e & 8'h0F, d);
         rdReg(3'h4); chk(8'h00, d);
         rdReg(3'h2); chk(i[0] ? 8'h00 : 8'h20, d);
      end
      $display("test masks and device events done");
      wrReg(3'h1, 8'h20);
      wrReg(3'h3, 8'h20);
      pulse(0);
      repeat (2) @(posedge clock);
      #1 chk(8'h07, {5'h0, srq, stb[6:5]});
      pulse(12);
      #1 chk(8'h03, {5'h0, srq, stb[6:5]});
      pulse(13);
      @(posedge clock) outQ <= 1'b1;
      repeat (2) @(posedge clock);
      #1 chk(8'h10, stb);
      for (i = 9; i < 11; i++) begin
         pulse(i);
         #1 chk(8'h03, {6'h0, clrIn, clrOut});
      end
      pulse(8);
      #1 chk(8'h03, {6'h0, remote, locked});
      pulse(7);
      #1 chk(8'h00, {7'h0, remote});
      pulse(11);
      #1 chk(8'h01, {7'h0, trig});
      @(posedge clock) #1 chk(8'h00, {7'h0, trig});
      @(posedge clock) remEn <= 1'b0;
      repeat (6) @(posedge clock);
      #1 chk(8'h00, {6'h0, remote, locked});
      $display("test requests and interface messages done");
      test_done;
   end
endmodule // instrument_event_status_bench
bind instrument_event_status instrument_event_status_assertions
   instrument_event_status_assertions_inst (.*);
